// *** nvm_pkg.sv ***
// Purpose: shared constants and types for the memory access controller
// Assumes: byte-addressed 16-bit data space, 16-bit flash words
// Notes:   offsets are byte addresses inside the I/O region
package nvm_pkg;
	// data space map
	localparam logic [15:0] EE_BASE       = 16'h1000;
	localparam logic [15:0] SRAM_BASE     = 16'h2000;
	localparam logic [5:0]  BIT_IO_LAST   = 6'h1f;
	localparam int          GPIO_COUNT    = 4;
	// control registers in I/O space
	localparam logic [15:0] REG_LOCK      = 16'h01c0;
	localparam logic [15:0] REG_STATUS    = 16'h01c1;
	localparam logic [15:0] REG_FUSE      = 16'h01c2;
	localparam logic [15:0] REG_DEVID0    = 16'h01c3;
	localparam logic [15:0] REG_DEVID1    = 16'h01c4;
	localparam logic [15:0] REG_DEVID2    = 16'h01c5;
	localparam logic [15:0] REG_REVID     = 16'h01c6;
	localparam logic [15:0] REG_PSIG_IDX  = 16'h01c7;
	localparam logic [15:0] REG_PSIG_DATA = 16'h01c8;
	localparam logic [15:0] REG_USIG_IDX  = 16'h01c9;
	localparam logic [15:0] REG_USIG_LO   = 16'h01ca;
	localparam logic [15:0] REG_USIG_HI   = 16'h01cb;
	localparam int          ST_BUSY       = 0;
	localparam int          ST_REJECT     = 1;
	// access latencies in cycles
	localparam logic [1:0]  LAT_IO        = 2'h1;
	localparam logic [1:0]  LAT_SRAM_WR   = 2'h1;
	localparam logic [1:0]  LAT_SRAM_RD   = 2'h2;
	localparam logic [1:0]  LAT_SRAM_BST  = 2'h1;
	localparam logic [1:0]  LAT_EE_WR     = 2'h1;
	localparam logic [1:0]  LAT_EE_RD     = 2'h3;
	localparam logic [1:0]  LAT_EE_BST    = 2'h2;
	// lock byte: two bits per section, bit0 write permit, bit1 read permit
	localparam int          LOCK_APP_LSB  = 0;
	localparam int          LOCK_TBL_LSB  = 2;
	localparam int          LOCK_BOOT_LSB = 4;
	localparam int          LOCK_WR_BIT   = 0;
	localparam int          LOCK_RD_BIT   = 1;
	localparam logic [7:0]  LOCK_ERASED   = 8'hff;
	localparam logic [7:0]  FUSE_ERASED   = 8'hff;
	localparam logic [15:0] FLASH_ERASED  = 16'hffff;
	// production row byte layout
	localparam logic [7:0]  PSIG_CAL_OSC  = 8'h00;
	localparam logic [7:0]  PSIG_CAL_ADC  = 8'h01;
	localparam logic [7:0]  PSIG_CAL_DAC  = 8'h02;
	localparam logic [7:0]  PSIG_LOT0     = 8'h03;
	localparam logic [7:0]  PSIG_LOT1     = 8'h04;
	localparam logic [7:0]  PSIG_LOT2     = 8'h05;
	localparam logic [7:0]  PSIG_WAFER    = 8'h06;
	localparam logic [7:0]  PSIG_X0       = 8'h07;
	localparam logic [7:0]  PSIG_X1       = 8'h08;
	localparam logic [7:0]  PSIG_Y0       = 8'h09;
	localparam logic [7:0]  PSIG_Y1       = 8'h0a;
	typedef logic [3:0] nvm_pcmd_t;
	localparam nvm_pcmd_t   PCMD_FLASH_RD = 4'h0;
	localparam nvm_pcmd_t   PCMD_FLASH_WR = 4'h1;
	localparam nvm_pcmd_t   PCMD_CHIP_ER  = 4'h2;
	localparam nvm_pcmd_t   PCMD_FUSE_WR  = 4'h3;
	localparam nvm_pcmd_t   PCMD_FUSE_RD  = 4'h4;
	localparam nvm_pcmd_t   PCMD_LOCK_WR  = 4'h5;
	localparam nvm_pcmd_t   PCMD_LOCK_RD  = 4'h6;
	localparam nvm_pcmd_t   PCMD_USIG_WR  = 4'h7;
	localparam nvm_pcmd_t   PCMD_USIG_RD  = 4'h8;
	localparam nvm_pcmd_t   PCMD_USIG_ER  = 4'h9;
	localparam nvm_pcmd_t   PCMD_PSIG_RD  = 4'ha;
	localparam nvm_pcmd_t   PCMD_PSIG_WR  = 4'hb;
	typedef logic [1:0] nvm_scmd_t;
	localparam nvm_scmd_t   SCMD_FLASH_WR = 2'h0;
	localparam nvm_scmd_t   SCMD_USIG_WR  = 2'h1;
	localparam nvm_scmd_t   SCMD_USIG_ER  = 2'h2;
	typedef logic [2:0] nvm_iop_t;
	localparam nvm_iop_t    IOP_IN        = 3'h0;
	localparam nvm_iop_t    IOP_OUT       = 3'h1;
	localparam nvm_iop_t    IOP_SET       = 3'h2;
	localparam nvm_iop_t    IOP_CLR       = 3'h3;
	localparam nvm_iop_t    IOP_TEST      = 3'h4;
	typedef enum logic [1:0] {MEM_NONE, MEM_IO, MEM_EE, MEM_SRAM} nvm_mem_e;
	typedef enum logic [1:0] {NV_IDLE, NV_PROG, NV_ERASE, NV_LOCKCLR} nvm_state_e;
	typedef enum logic [1:0] {OP_FLASH_WR, OP_USIG_WR, OP_USIG_ER} nvm_op_e;
endpackage

// *** nvm_mem_ctrl.sv ***
// Purpose: flash sections, locks, signature rows and data memory access
// Assumes: CPU on Avalon-MM, DMA on a second port, programmer on plain ports
// Notes:   nonvolatile arrays are plain flops here, not reset
`timescale 1ns/1ps
module nvm_mem_ctrl #(
	parameter int          APP_WORDS  = 16384,
	parameter int          BOOT_WORDS = 2048,
	parameter int          PAGE_WORDS = 64,
	parameter int          EE_BYTES   = 1024,
	parameter int          SRAM_BYTES = 4096,
	parameter int          PROG_CYCLES = 4,
	parameter logic [23:0] DEVICE_ID  = 24'h5a3c01, // arbitrary value
	parameter logic [7:0]  REVISION   = 8'h01,      // arbitrary value
	parameter logic [7:0]  CAL_OSC    = 8'h80,
	parameter logic [7:0]  CAL_ADC    = 8'h40,
	parameter logic [7:0]  CAL_DAC    = 8'h20,
	parameter logic [23:0] LOT_NUM    = 24'h000001,
	parameter logic [7:0]  WAFER_NUM  = 8'h01,
	parameter logic [15:0] DIE_X      = 16'h0001,
	parameter logic [15:0] DIE_Y      = 16'h0001,
	localparam int         FA_W       = $clog2(APP_WORDS + BOOT_WORDS)
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic [15:0]       avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [7:0]        avs_writedata,
	output logic [7:0]             avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic              dmaRead,
	input  wire logic              dmaWrite,
	input  wire logic [15:0]       dmaAddr,
	input  wire logic [7:0]        dmaWdata,
	output logic [7:0]             dmaRdata,
	output logic                   dmaWait,
	input  wire logic              ioOpValid,
	input  wire nvm_pkg::nvm_iop_t ioOpKind,
	input  wire logic [5:0]        ioOpAddr,
	input  wire logic [2:0]        ioOpBit,
	input  wire logic [7:0]        ioOpWdata,
	output logic [7:0]             ioOpRdata_q,
	input  wire logic              spmReq,
	input  wire logic              spmFromBoot,
	input  wire nvm_pkg::nvm_scmd_t spmCmd,
	input  wire logic [FA_W-1:0]   spmAddr,
	input  wire logic [15:0]       spmData,
	output logic                   cpuStall,
	input  wire logic [FA_W-1:0]   fetchAddr,
	output logic [15:0]            fetchData_q,
	input  wire logic              progReq,
	input  wire nvm_pkg::nvm_pcmd_t progCmd,
	input  wire logic [FA_W-1:0]   progAddr,
	input  wire logic [15:0]       progWdata,
	output logic                   progBusy,
	output logic [15:0]            progRdata_q,
	output logic [7:0]             calOsc_q,
	output logic [7:0]             calAdc_q
);
	import nvm_pkg::*;
	localparam int FLASH_WORDS = APP_WORDS + BOOT_WORDS;
	localparam int TBL_START   = APP_WORDS - BOOT_WORDS;
	localparam int EA_W        = $clog2(EE_BYTES);
	localparam int SA_W        = $clog2(SRAM_BYTES);
	localparam int PW_W        = $clog2(PAGE_WORDS);
	localparam int CNT_W       = $clog2(FLASH_WORDS + 1);
	localparam logic [CNT_W-1:0] PROG_LAST  = CNT_W'(PROG_CYCLES - 1);
	localparam logic [CNT_W-1:0] ERASE_LAST = CNT_W'(FLASH_WORDS - 1);

	logic [15:0] flashMem [FLASH_WORDS];
	logic [15:0] usigMem  [PAGE_WORDS];
	logic [7:0]  eeMem    [EE_BYTES];
	logic [7:0]  sramMem  [SRAM_BYTES];
	logic [7:0]  gpio_q   [GPIO_COUNT];
	logic [7:0]  lock_q;
	logic [7:0]  fuse_q;
	logic        reject_q;
	logic [7:0]  psigIdx_q;
	logic [7:0]  usigIdx_q;

	////////////////////////////////////////////////////////////////////////////////
	function automatic nvm_mem_e memOf(input logic [15:0] a);
		if (a < EE_BASE)
			return MEM_IO;
		if (int'(a) < int'(EE_BASE) + EE_BYTES)
			return MEM_EE;
		if (a >= SRAM_BASE && int'(a) < int'(SRAM_BASE) + SRAM_BYTES)
			return MEM_SRAM;
		return MEM_NONE;
	endfunction

	function automatic logic [1:0] latOf(input nvm_mem_e m, input logic wr, input logic bst);
		case (m)
			MEM_SRAM: return wr ? LAT_SRAM_WR : (bst ? LAT_SRAM_BST : LAT_SRAM_RD);
			MEM_EE:   return wr ? LAT_EE_WR : (bst ? LAT_EE_BST : LAT_EE_RD);
			default:  return LAT_IO;
		endcase
	endfunction

	// table region is boot-sized and sits at the top of the application area
	function automatic logic [1:0] lockOf(input logic [FA_W-1:0] a);
		if (int'(a) >= APP_WORDS)
			return lock_q[LOCK_BOOT_LSB +: 2];
		if (int'(a) >= TBL_START)
			return lock_q[LOCK_TBL_LSB +: 2];
		return lock_q[LOCK_APP_LSB +: 2];
	endfunction

	function automatic logic [7:0] psigByte(input logic [7:0] i);
		case (i)
			PSIG_CAL_OSC: return CAL_OSC;
			PSIG_CAL_ADC: return CAL_ADC;
			PSIG_CAL_DAC: return CAL_DAC;
			PSIG_LOT0:    return LOT_NUM[7:0];
			PSIG_LOT1:    return LOT_NUM[15:8];
			PSIG_LOT2:    return LOT_NUM[23:16];
			PSIG_WAFER:   return WAFER_NUM;
			PSIG_X0:      return DIE_X[7:0];
			PSIG_X1:      return DIE_X[15:8];
			PSIG_Y0:      return DIE_Y[7:0];
			PSIG_Y1:      return DIE_Y[15:8];
			default:      return 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] ioRead(input logic [15:0] a);
		if (int'(a) < GPIO_COUNT)
			return gpio_q[a[1:0]];
		case (a)
			REG_LOCK:      return lock_q;
			REG_STATUS:    return 8'h00 | {6'h00, reject_q, progBusy};
			REG_FUSE:      return fuse_q;
			REG_DEVID0:    return DEVICE_ID[7:0];
			REG_DEVID1:    return DEVICE_ID[15:8];
			REG_DEVID2:    return DEVICE_ID[23:16];
			REG_REVID:     return REVISION;
			REG_PSIG_DATA: return psigByte(psigIdx_q);
			REG_USIG_LO:   return usigMem[usigIdx_q[PW_W-1:0]][7:0];
			REG_USIG_HI:   return usigMem[usigIdx_q[PW_W-1:0]][15:8];
			default:       return 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] memRead(input logic [15:0] a, input nvm_mem_e m);
		logic [15:0] off;
		off = a - ((m == MEM_EE) ? EE_BASE : SRAM_BASE);
		case (m)
			MEM_IO:   return ioRead(a);
			MEM_EE:   return eeMem[off[EA_W-1:0]];
			MEM_SRAM: return sramMem[off[SA_W-1:0]];
			default:  return 8'h00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// CPU slave and DMA port
	logic [1:0] cpuCnt_q;
	logic [1:0] dmaCnt_q;
	logic       dmaSeq_q;
	logic       dmaBstHold_q;
	logic [15:0] dmaNext_q;

	wire       cpuReq   = avs_read | avs_write;
	nvm_mem_e  cpuMem;
	assign     cpuMem   = memOf(avs_address);
	wire [1:0] cpuLat   = latOf(cpuMem, avs_write, 1'b0);
	assign avs_waitrequest = cpuReq && ({1'b0, cpuCnt_q} + 3'h1 < {1'b0, cpuLat});
	wire       cpuDone  = cpuReq && !avs_waitrequest;
	assign avs_readdata = memRead(avs_address, cpuMem);

	wire       dmaReq   = dmaRead | dmaWrite;
	nvm_mem_e  dmaMem;
	assign     dmaMem   = memOf(dmaAddr);
	wire       dmaBstNew = dmaRead && dmaSeq_q && (dmaAddr == dmaNext_q);
	wire       dmaBst   = (dmaCnt_q == 2'h0) ? dmaBstNew : dmaBstHold_q;
	wire [1:0] dmaLat   = latOf(dmaMem, dmaWrite, dmaBst);
	// same memory: CPU first, DMA waits
	wire       dmaBlocked = cpuReq && dmaReq && (cpuMem == dmaMem) && (dmaMem != MEM_NONE);
	assign dmaWait  = dmaReq && (dmaBlocked || ({1'b0, dmaCnt_q} + 3'h1 < {1'b0, dmaLat}));
	wire       dmaDone  = dmaReq && !dmaWait;
	assign dmaRdata = memRead(dmaAddr, dmaMem);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cpuCnt_q     <= 2'h0;
			dmaCnt_q     <= 2'h0;
			dmaSeq_q     <= 1'b0;
			dmaBstHold_q <= 1'b0;
			dmaNext_q    <= 16'h0000;
		end else begin
			cpuCnt_q     <= (cpuDone || !cpuReq) ? 2'h0 : cpuCnt_q + 2'h1;
			dmaCnt_q     <= (dmaDone || !dmaReq) ? 2'h0 : dmaCnt_q + {1'b0, !dmaBlocked};
			dmaSeq_q     <= dmaDone && dmaRead;
			dmaBstHold_q <= dmaBst;
			dmaNext_q    <= dmaAddr + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// data memory writes
	wire cpuWr = cpuDone && avs_write;
	wire dmaWr = dmaDone && dmaWrite;
	wire eeWr  = (cpuWr && cpuMem == MEM_EE) || (dmaWr && dmaMem == MEM_EE);
	wire srWr  = (cpuWr && cpuMem == MEM_SRAM) || (dmaWr && dmaMem == MEM_SRAM);
	wire ioWr  = (cpuWr && cpuMem == MEM_IO) || (dmaWr && dmaMem == MEM_IO);
	wire useCpu = cpuWr;
	wire [15:0] wrAddr = useCpu ? avs_address : dmaAddr;
	wire [7:0]  wrData = useCpu ? avs_writedata : dmaWdata;
	wire [15:0] eeOff  = wrAddr - EE_BASE;
	wire [15:0] srOff  = wrAddr - SRAM_BASE;

	always_ff @(posedge sys_clk) begin
		if (eeWr)
			eeMem[eeOff[EA_W-1:0]] <= wrData;
		if (srWr)
			sramMem[srOff[SA_W-1:0]] <= wrData;
	end

	// short I/O port: IN/OUT reach 0x00-0x3F, bit ops only up to 0x1F
	wire bitOk   = ioOpAddr <= BIT_IO_LAST;
	wire opGpio  = int'(ioOpAddr) < GPIO_COUNT;
	wire [7:0] opCur = ioRead({10'h000, ioOpAddr});
	wire opSet   = ioOpValid && ioOpKind == IOP_SET && bitOk;
	wire opClr   = ioOpValid && ioOpKind == IOP_CLR && bitOk;
	wire opOut   = ioOpValid && ioOpKind == IOP_OUT;
	wire [7:0] bitMask = 8'h01 << ioOpBit;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			for (int i = 0; i < GPIO_COUNT; i++)
				gpio_q[i] <= 8'h00;
			ioOpRdata_q <= 8'h00;
		end else begin
			if (ioWr && int'(wrAddr) < GPIO_COUNT)
				gpio_q[wrAddr[1:0]] <= wrData;
			if (opGpio && opOut)
				gpio_q[ioOpAddr[1:0]] <= ioOpWdata;
			else if (opGpio && (opSet || opClr))
				gpio_q[ioOpAddr[1:0]] <= opSet ? (opCur | bitMask) : (opCur & ~bitMask);
			if (ioOpValid && ioOpKind == IOP_IN)
				ioOpRdata_q <= opCur;
			else if (ioOpValid && ioOpKind == IOP_TEST && bitOk)
				ioOpRdata_q <= {7'h00, opCur[ioOpBit]};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// programming engine
	nvm_state_e       state_q;
	nvm_op_e          op_q;
	logic [FA_W-1:0]  opAddr_q;
	logic [15:0]      opData_q;
	logic             opCpu_q;
	logic [CNT_W-1:0] cnt_q;

	wire idle      = state_q == NV_IDLE;
	wire progTake  = progReq && idle;
	wire spmTake   = spmReq && idle && !progReq;
	wire [1:0] spmLock  = lockOf(spmAddr);
	wire [1:0] progLock = lockOf(progAddr);
	wire spmWrOk   = spmLock[LOCK_WR_BIT];
	wire progWrOk  = progLock[LOCK_WR_BIT];
	wire spmLegal  = spmFromBoot && (spmCmd != SCMD_FLASH_WR || spmWrOk);
	wire progFlWr  = progTake && progCmd == PCMD_FLASH_WR;
	wire progUsig  = progTake && (progCmd == PCMD_USIG_WR || progCmd == PCMD_USIG_ER);
	wire progStart = (progFlWr && progWrOk) || progUsig;
	wire spmStart  = spmTake && spmLegal;
	wire ceStart   = progTake && progCmd == PCMD_CHIP_ER;
	wire rejectEvt = (spmTake && !spmLegal) || (progFlWr && !progWrOk)
		|| (progTake && progCmd == PCMD_PSIG_WR);
	wire commit    = state_q == NV_PROG && cnt_q == PROG_LAST;
	wire [15:0] stClrOff = wrAddr;
	wire rejClr    = ioWr && stClrOff == REG_STATUS && wrData[ST_REJECT];

	nvm_op_e newOp;
	assign newOp = spmStart ? ((spmCmd == SCMD_USIG_WR) ? OP_USIG_WR
		: (spmCmd == SCMD_USIG_ER) ? OP_USIG_ER : OP_FLASH_WR)
		: ((progCmd == PCMD_USIG_WR) ? OP_USIG_WR
		: (progCmd == PCMD_USIG_ER) ? OP_USIG_ER : OP_FLASH_WR);

	assign cpuStall = (spmReq && !spmTake) || (state_q == NV_PROG && opCpu_q);
	assign progBusy = !idle;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q  <= NV_IDLE;
			op_q     <= OP_FLASH_WR;
			opAddr_q <= '0;
			opData_q <= 16'h0000;
			opCpu_q  <= 1'b0;
			cnt_q    <= '0;
		end else begin
			case (state_q)
				NV_IDLE: begin
					cnt_q <= '0;
					if (ceStart)
						state_q <= NV_ERASE;
					else if (progStart || spmStart)
						state_q <= NV_PROG;
					op_q     <= newOp;
					opAddr_q <= spmStart ? spmAddr : progAddr;
					opData_q <= spmStart ? spmData : progWdata;
					opCpu_q  <= spmStart;
				end
				NV_PROG: begin
					cnt_q <= cnt_q + 1'b1;
					if (commit)
						state_q <= NV_IDLE;
				end
				NV_ERASE: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q == ERASE_LAST)
						state_q <= NV_LOCKCLR;
				end
				NV_LOCKCLR: state_q <= NV_IDLE;
				default:    state_q <= NV_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (commit && op_q == OP_FLASH_WR)
			flashMem[opAddr_q] <= opData_q;
		else if (state_q == NV_ERASE)
			flashMem[cnt_q[FA_W-1:0]] <= FLASH_ERASED;
		// chip erase leaves the user row alone
		if (commit && op_q == OP_USIG_WR)
			usigMem[opAddr_q[PW_W-1:0]] <= opData_q;
		else if (commit && op_q == OP_USIG_ER)
			for (int i = 0; i < PAGE_WORDS; i++)
				usigMem[i] <= FLASH_ERASED;
		fetchData_q <= flashMem[fetchAddr];
	end

	////////////////////////////////////////////////////////////////////////////////
	// locks, fuses, status, index registers
	wire swLockWr = ioWr && wrAddr == REG_LOCK;
	wire prLockWr = progTake && progCmd == PCMD_LOCK_WR;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			lock_q    <= LOCK_ERASED;
			fuse_q    <= FUSE_ERASED;
			reject_q  <= 1'b0;
			psigIdx_q <= 8'h00;
			usigIdx_q <= 8'h00;
		end else begin
			if (state_q == NV_LOCKCLR)
				lock_q <= LOCK_ERASED;
			else if (swLockWr || prLockWr)
				lock_q <= lock_q & (prLockWr ? progWdata[7:0] : wrData);
			if (progTake && progCmd == PCMD_FUSE_WR)
				fuse_q <= progWdata[7:0];
			reject_q <= rejectEvt || (reject_q && !rejClr);
			if (ioWr && wrAddr == REG_PSIG_IDX)
				psigIdx_q <= wrData;
			if (ioWr && wrAddr == REG_USIG_IDX)
				usigIdx_q <= wrData;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			progRdata_q <= 16'h0000;
			calOsc_q    <= CAL_OSC;
			calAdc_q    <= CAL_ADC;
		end else if (progTake) begin
			case (progCmd)
				PCMD_FLASH_RD: progRdata_q <= progLock[LOCK_RD_BIT]
					? flashMem[progAddr] : FLASH_ERASED;
				PCMD_USIG_RD:  progRdata_q <= usigMem[progAddr[PW_W-1:0]];
				PCMD_PSIG_RD:  progRdata_q <= {8'h00, psigByte(progAddr[7:0])};
				PCMD_FUSE_RD:  progRdata_q <= {8'h00, fuse_q};
				PCMD_LOCK_RD:  progRdata_q <= {8'h00, lock_q};
				default:       progRdata_q <= progRdata_q;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	bootOnly_a: assert property (spmTake && !spmFromBoot |=> idle && reject_q)
		else $error("flash write accepted outside boot section");
	stallRun_a: assert property (spmStart |=> cpuStall && state_q == NV_PROG)
		else $error("cpu not stalled during programming");
	lockedWr_a: assert property (progFlWr && !progWrOk |=> idle)
		else $error("locked section write started");
	lockStrict_a: assert property (state_q != NV_LOCKCLR |=> (lock_q & ~$past(lock_q)) == 8'h00)
		else $error("lock bits relaxed");
	lockLate_a: assert property (state_q == NV_ERASE |=> $stable(lock_q) || state_q == NV_LOCKCLR)
		else $error("locks changed during flash erase");
	fuseRo_a: assert property (!(progTake && progCmd == PCMD_FUSE_WR) |=> $stable(fuse_q))
		else $error("fuse changed without programmer");
	ioLat_a: assert property (cpuReq && cpuMem == MEM_IO |-> !avs_waitrequest)
		else $error("io access not single cycle");
	sramRd_a: assert property (avs_read && cpuMem == MEM_SRAM && cpuCnt_q == 2'h0
		|-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("sram read latency wrong");
	eeRd_a: assert property (avs_read && cpuMem == MEM_EE && cpuCnt_q == 2'h0
		|-> avs_waitrequest[*2] ##1 !avs_waitrequest)
		else $error("eeprom read latency wrong");
	dmaPar_a: assert property (dmaRead && dmaMem == MEM_IO && cpuReq && cpuMem != MEM_IO
		|-> !dmaWait)
		else $error("dma held off on a free memory");

	progCov_c:  cover property (spmStart ##[1:20] commit);
	eraseCov_c: cover property (state_q == NV_ERASE ##1 state_q == NV_LOCKCLR);
	bstCov_c:   cover property (dmaDone && dmaRead ##1 dmaDone && dmaBst);
	blockCov_c: cover property (dmaBlocked ##1 !dmaBlocked ##[0:3] dmaDone);

endmodule // nvm_mem_ctrl

// *** nvm_prog_model.sv ***
// Purpose: programmer model on the program debug port
// Assumes: one command at a time, taken while the engine is idle
// Notes:   released address and data lines show the inverse value
`timescale 1ns/1ps
module nvm_prog_model (
	input  wire logic          sys_clk,
	input  wire logic          progBusy,
	input  wire logic [15:0]   progRdata_q,
	output logic               progReq,
	output nvm_pkg::nvm_pcmd_t progCmd,
	output logic [6:0]         progAddr,
	output logic [15:0]        progWdata
);
	import nvm_pkg::*;
	initial {progReq, progCmd, progAddr, progWdata} = '0;
	task automatic cmd(input nvm_pcmd_t c, input logic [6:0] a,
		input logic [15:0] d, output logic [15:0] q);
		{progReq, progCmd, progAddr, progWdata} <= {1'b1, c, a, d};
		do @(negedge sys_clk); while (progBusy !== 1'b0);
		@(posedge sys_clk) {progReq, progAddr, progWdata} <= {1'b0, ~a, ~d};
		@(negedge sys_clk) q = progRdata_q;
		while (progBusy !== 1'b0) @(negedge sys_clk);
		@(posedge sys_clk);
	endtask
endmodule // nvm_prog_model

// *** tb_top.sv ***
// Purpose: self-checking bench for the memory access controller
// Assumes: 64+16 word flash keeps chip erase short
// Notes:   programmer side is the partner model
`timescale 1ns/1ps
module tb_top;
	import nvm_pkg::*;
	localparam int PC = 4;
	logic        sys_clk = 0, rst = 1, avs_read = 0, avs_write = 0, dmaRead = 0, dmaWrite = 0;
	logic        ioOpValid = 0, spmReq = 0, spmFromBoot = 0;
	logic        avs_waitrequest, dmaWait, cpuStall, progReq, progBusy;
	logic [15:0] avs_address = 0, dmaAddr = 0, spmData = 0, fetchData_q, progRdata_q, progWdata;
	logic [7:0]  avs_writedata = 0, dmaWdata = 0, ioOpWdata = 0, avs_readdata, dmaRdata, r;
	logic [7:0]  ioOpRdata_q, calOsc_q, calAdc_q;
	logic [6:0]  spmAddr = 0, fetchAddr = 0, progAddr;
	logic [5:0]  ioOpAddr = 0;
	logic [2:0]  ioOpBit = 0;
	logic [15:0] d, a, q;
	nvm_iop_t    ioOpKind = IOP_IN;
	nvm_scmd_t   spmCmd = SCMD_FLASH_WR;
	nvm_pcmd_t   progCmd;
	int          mismatches = 0, totalChecks = 0, cyc = 0, n, seed = 59742;
	nvm_mem_ctrl #(.APP_WORDS(64), .BOOT_WORDS(16), .PAGE_WORDS(8), .PROG_CYCLES(PC)) dut (
		.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .dmaRead, .dmaWrite, .dmaAddr, .dmaWdata, .dmaRdata, .dmaWait,
		.ioOpValid, .ioOpKind, .ioOpAddr, .ioOpBit, .ioOpWdata, .ioOpRdata_q, .spmReq,
		.spmFromBoot, .spmCmd, .spmAddr, .spmData, .cpuStall, .fetchAddr, .fetchData_q,
		.progReq, .progCmd, .progAddr, .progWdata, .progBusy, .progRdata_q, .calOsc_q, .calAdc_q);
	nvm_prog_model prog (.sys_clk, .progBusy, .progRdata_q, .progReq, .progCmd, .progAddr,
		.progWdata);
	////////////////////////////////////////////////////////////////////////////////
	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			test_done();
		end
	end
	task automatic test_done();
		if (mismatches == 0 && totalChecks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, e);
		totalChecks++;
		if (g !== e) $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		mismatches += int'(g !== e);
	endtask
	task automatic bus(input logic w, input logic [15:0] ad, input logic [7:0] wd);
		{avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, ad, wd};
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0);
		r = avs_readdata;
		{avs_write, avs_read} <= 2'b00;
		@(posedge sys_clk);
	endtask
	task automatic io(input nvm_iop_t k, input logic [2:0] b, input logic [7:0] wd);
		{ioOpValid, ioOpKind, ioOpAddr, ioOpBit, ioOpWdata} <= {1'b1, k, 6'h02, b, wd};
		@(posedge sys_clk) ioOpValid <= 1'b0;
		@(posedge sys_clk);
	endtask
	// n ends as the number of stalled cycles
	task automatic flash_write_instruction(input logic fb, input logic [6:0] ad, input logic [15:0] dd);
		{spmReq, spmFromBoot, spmAddr, spmData} <= {1'b1, fb, ad, dd};
		do @(negedge sys_clk); while (cpuStall !== 1'b0);
		@(posedge sys_clk) spmReq <= 1'b0;
		n = -1;
		do @(negedge sys_clk) n++; while (cpuStall === 1'b1);
		@(posedge sys_clk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		chk(calOsc_q, 8'h80);
		chk(calAdc_q, 8'h40);
		bus(0, REG_LOCK, 0);
		chk(r, LOCK_ERASED);
		chk(n[15:0], 1);
		for (int i = 0; i < 3; i++) begin
			bus(0, REG_DEVID0 + i[15:0], 0);
			chk(r, 8'(24'h5a3c01 >> (8 * i)));
		end
		bus(1, 16'h1800, 8'h5a);
		bus(0, 16'h1800, 0);
		chk(r, 8'h00);
		for (int k = 0; k < 6; k++) begin
			a = k[0] ? EE_BASE + 16'($random(seed) & 'h3ff) : SRAM_BASE + 16'($random(seed) & 'h7ff);
			d = 16'($random(seed));
			bus(1, a, d[7:0]);
			chk(n[15:0], 1);
			bus(0, a, 0);
			chk({n[7:0], r}, {k[0] ? 8'd3 : 8'd2, d[7:0]});
		end
		fork
			bus(0, EE_BASE, 0);
			begin
				{dmaWrite, dmaAddr, dmaWdata} <= {1'b1, SRAM_BASE + 16'h0800, 8'h3c};
				@(posedge sys_clk) chk(dmaWait, 0);
				dmaWrite <= 1'b0;
			end
		join
		{dmaRead, dmaAddr} <= {1'b1, SRAM_BASE + 16'h0800};
		do @(posedge sys_clk); while (dmaWait !== 1'b0);
		chk(dmaRdata, 8'h3c);
		dmaRead <= 1'b0;
		@(posedge sys_clk);
		bus(0, SRAM_BASE + 16'h0800, 0);
		chk(r, 8'h3c);
		io(IOP_OUT, 0, 8'ha5);
		io(IOP_SET, 1, 0);
		io(IOP_CLR, 0, 0);
		io(IOP_IN, 0, 0);
		chk(ioOpRdata_q, 8'ha6);
		io(IOP_TEST, 1, 0);
		chk(ioOpRdata_q, 8'h01);
		bus(0, 16'h0002, 0);
		chk(r, 8'ha6);
		flash_write_instruction(0, 7'd3, 16'h1234);
		chk(n[15:0], 0);
		bus(0, REG_STATUS, 0);
		chk(r[ST_REJECT], 1);
		d = 16'($random(seed));
		flash_write_instruction(1, 7'd3, d);
		chk(n[15:0], PC);
		flash_write_instruction(1, 7'd70, ~d);
		prog.cmd(PCMD_FLASH_RD, 7'd70, 0, q);
		chk(q, ~d);
		fetchAddr <= 7'd70;
		repeat (2) @(posedge sys_clk);
		chk(fetchData_q, ~d);
		bus(1, REG_LOCK, 8'hfe);
		bus(1, REG_LOCK, 8'hff);
		bus(0, REG_LOCK, 0);
		chk(r, 8'hfe);
		flash_write_instruction(1, 7'd3, 16'h0000);
		prog.cmd(PCMD_FLASH_RD, 7'd3, 0, q);
		chk({n[15:0], q}, {16'h0, d});
		flash_write_instruction(1, 7'd50, 16'h55aa);
		chk(n[15:0], PC);
		prog.cmd(PCMD_FUSE_WR, 0, 16'h007e, q);
		bus(1, REG_FUSE, 8'h00);
		bus(0, REG_FUSE, 0);
		chk(r, 8'h7e);
		prog.cmd(PCMD_PSIG_WR, 7'd6, 0, q);
		bus(1, REG_PSIG_IDX, PSIG_WAFER);
		bus(0, REG_PSIG_DATA, 0);
		chk(r, 8'h01);
		prog.cmd(PCMD_USIG_WR, 7'd1, 16'hbeef, q);
		prog.cmd(PCMD_CHIP_ER, 0, 0, q);
		bus(0, REG_LOCK, 0);
		prog.cmd(PCMD_FLASH_RD, 7'd3, 0, q);
		chk({r, q[7:0]}, {LOCK_ERASED, FLASH_ERASED[7:0]});
		prog.cmd(PCMD_USIG_RD, 7'd1, 0, q);
		chk(q, 16'hbeef);
		prog.cmd(PCMD_USIG_ER, 0, 0, q);
		prog.cmd(PCMD_USIG_RD, 7'd1, 0, q);
		chk(q, FLASH_ERASED);
		test_done();
	end
endmodule // tb_top
